// *** pkg/uis_pkg.sv ***
// Constants, register map and carrier types of the serial port slice
package uis_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_BAUD_HIGH    = 4'h0;
	localparam logic [3:0] IDX_BAUD_LOW     = 4'h1;
	localparam logic [3:0] IDX_CONTROL_ONE  = 4'h2;
	localparam logic [3:0] IDX_STATUS_TWO   = 4'h5;
	localparam logic [3:0] IDX_DATA_HIGH    = 4'h6;
	localparam logic [3:0] IDX_DATA_LOW     = 4'h7;
	localparam logic [3:0] IDX_PORT_CONTROL = 4'h8;
	localparam logic [3:0] IDX_IRQ_STATUS   = 4'h9;
	localparam logic [3:0] IDX_IRQ_MASK     = 4'hA;
	// status_two_control fields
	localparam int ALT_MAP_BIT     = 7;
	localparam int TX_INVERT_BIT   = 4;
	localparam int RX_INVERT_BIT   = 3;
	localparam int LONG_BREAK_BIT  = 2;
	localparam int TX_DRIVE_BIT    = 1;
	localparam int RX_ACTIVE_BIT   = 0;
	// data_high_ninth_bit fields
	localparam int RX_NINTH_BIT    = 7;
	localparam int TX_NINTH_BIT    = 6;
	// control_one field
	localparam int NINE_BIT_SEL    = 4;
	// port_control fields
	localparam int TX_EN_BIT       = 0;
	localparam int RX_EN_BIT       = 1;
	localparam int IR_EN_BIT       = 2;
	localparam int PW_LSB          = 3;
	localparam int SINGLE_WIRE_BIT = 5;
	localparam int SEND_BREAK_BIT  = 6;
	// Interrupt status bits
	localparam int EV_TX_EMPTY     = 0;
	localparam int EV_RX_FULL      = 1;
	localparam int EV_IDLE         = 2;
	localparam int EV_FRAME_ERR    = 3;
	// Reset values
	localparam logic [7:0] RST_BAUD_HIGH   = 8'h00;
	localparam logic [7:0] RST_BAUD_LOW    = 8'h04;
	localparam logic [7:0] RST_BYTE        = 8'h00;
	// Frame and timing figures
	localparam logic [3:0] FRAME_BITS_8    = 4'hA;
	localparam logic [3:0] BREAK_BITS_SHORT = 4'hA;
	localparam logic [3:0] BREAK_BITS_LONG = 4'hD;
	localparam logic [3:0] MID_SAMPLE      = 4'h8;
	localparam logic [4:0] BIT_CENTRE      = 5'h10;
	localparam logic [7:0] IDLE_TICKS_8    = 8'hA0;
	localparam logic [7:0] IDLE_TICKS_9    = 8'hB0;
	localparam logic [4:0] STRETCH_TICKS   = 5'h10;
	// Infrared pulse width select, named as fractions of a bit
	localparam logic [1:0] PW_3_16 = 2'h0;
	localparam logic [1:0] PW_1_16 = 2'h1;
	localparam logic [1:0] PW_1_32 = 2'h2;
	localparam logic [1:0] PW_1_4  = 2'h3;

	typedef struct packed {
		logic alt_map;
		logic tx_invert;
		logic rx_invert;
		logic long_break;
		logic single_wire_tx_drive;
	} uis_line_cfg_t;

	typedef struct packed {
		logic       single_wire;
		logic [1:0] pulse_width;
		logic       ir_en;
		logic       rx_en;
		logic       tx_en;
		logic       send_break;
	} uis_port_cfg_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_FRAME = 2'b01,
		TX_BREAK = 2'b10
	} uis_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_FRAME = 2'b01
	} uis_rx_state_t;
endpackage : uis_pkg

// *** logic/uis_top.sv ***
// Serial port slice: APB registers, NRZ/infrared transmit and receive paths
// Functional notes
// - Bit 7 of status two swaps baud/control one for alternate registers at 0-2.
// - Bit 4 inverts transmit line levels.
// - Bit 3 inverts how receive line levels are read.
// - Bit 2 picks break of 10/11 or 13/14 bits; framing check unchanged.
// - Bit 1 makes transmit pin an output in single-wire mode, else input.
// - Bit 0 read-only: set on zero in first sample slot, cleared on idle.
// - Data high bit 7 reads ninth received bit, bit 6 holds ninth transmit bit.
// - Ninth transmit bit stays and is reused until software rewrites it.
// - Data low reads received byte, writes transmit byte; received ninth bit is unwritable.
// - Data high bits 2:0 writable only in special mode.
// - Transmitter and receiver run independently from one baud generator.
// - Infrared sends centred narrow pulse per zero; width 1/32, 1/16, 3/16, 1/4.
// - Infrared pulse is high normally, low with line idling high when inverted.
// - Baud generator yields 16x and 32x ticks; decoder uses only 16x.
// - Infrared decoder stretches each received pulse into a zero bit.
// - Infrared path needs to cover 2.4 to 115.2 kbit/s only.
// - Nine-bit select gives 10-bit or 11-bit frames.
module uis_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Chip mode
	input  wire logic        special_mode,
	// Serial pins
	input  wire logic        rxd_in,
	input  wire logic        txd_in,
	output logic             txd_out,
	output logic             txd_oe_n,
	// Interrupt
	output logic             irq
);
	uis_pkg::uis_line_cfg_t line_q;
	uis_pkg::uis_port_cfg_t port_q;
	uis_pkg::uis_tx_state_t tx_state_q;
	uis_pkg::uis_rx_state_t rx_state_q;
	logic [7:0]  baud_hi_q, baud_lo_q, ctrl1_q;
	logic [7:0]  alt_q [3];
	logic [7:0]  tx_hold_q, rx_data_q, irq_st_q, irq_mask_q;
	logic        tx_ninth_q, rx_ninth_q, tdre_q, raf_q;
	logic [2:0]  test_q;
	logic [3:0]  idx;
	logic        aligned, wr, rd_setup, hit_ok;
	logic [7:0]  rd_val;
	logic        nine;
	logic [3:0]  frame_len;
	// Baud generator
	logic [15:0] sbr, half, div_cnt_q;
	logic        x32_tick, x16_tick, x16_ph_q;
	// Transmit path
	logic [10:0] tx_sh_q;
	logic [3:0]  tx_bits_q, brk_len;
	logic [4:0]  tx_ph_q, pw_len;
	logic        tx_bit, ir_pulse;
	// Receive path
	logic        rx_pin, rx_lvl, rx_bit;
	logic [4:0]  stretch_q;
	logic [3:0]  rx_cnt_q, rx_idx_q;
	logic [8:0]  rx_sh_q;
	logic [7:0]  ones_q;
	logic        idle_armed_q, rx_done, rx_stop_bit;
	logic [7:0]  ev;

	assign nine      = ctrl1_q[uis_pkg::NINE_BIT_SEL];
	assign frame_len = uis_pkg::FRAME_BITS_8 + {3'h0, nine};

	// APB decode, zero wait state
	assign idx      = paddr[5:2];
	assign aligned  = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
	assign hit_ok   = aligned && (idx <= uis_pkg::IDX_IRQ_MASK) && (idx != 4'h3) && (idx != 4'h4);
	assign wr       = psel && penable && pwrite && hit_ok;
	assign rd_setup = psel && !penable;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !hit_ok;

	always_comb begin
		rd_val = 8'h00;
		if (idx == uis_pkg::IDX_BAUD_HIGH) begin
			rd_val = line_q.alt_map ? alt_q[0] : baud_hi_q;
		end else if (idx == uis_pkg::IDX_BAUD_LOW) begin
			rd_val = line_q.alt_map ? alt_q[1] : baud_lo_q;
		end else if (idx == uis_pkg::IDX_CONTROL_ONE) begin
			rd_val = line_q.alt_map ? alt_q[2] : ctrl1_q;
		end else if (idx == uis_pkg::IDX_STATUS_TWO) begin
			rd_val = {line_q.alt_map, 2'h0, line_q.tx_invert, line_q.rx_invert,
				line_q.long_break, line_q.single_wire_tx_drive, raf_q};
		end else if (idx == uis_pkg::IDX_DATA_HIGH) begin
			rd_val = {rx_ninth_q, tx_ninth_q, 3'h0, test_q};
		end else if (idx == uis_pkg::IDX_DATA_LOW) begin
			rd_val = rx_data_q;
		end else if (idx == uis_pkg::IDX_PORT_CONTROL) begin
			rd_val = {1'b0, port_q.send_break, port_q.single_wire, port_q.pulse_width,
				port_q.ir_en, port_q.rx_en, port_q.tx_en};
		end else if (idx == uis_pkg::IDX_IRQ_STATUS) begin
			rd_val = irq_st_q;
		end else if (idx == uis_pkg::IDX_IRQ_MASK) begin
			rd_val = irq_mask_q;
		end
	end

	// Read data captured in setup so it comes from a flop in access
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= {24'h00_0000, hit_ok ? rd_val : 8'h00};
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			baud_hi_q <= uis_pkg::RST_BAUD_HIGH;
			baud_lo_q <= uis_pkg::RST_BAUD_LOW;
			ctrl1_q   <= uis_pkg::RST_BYTE;
			alt_q[0]  <= uis_pkg::RST_BYTE;
			alt_q[1]  <= uis_pkg::RST_BYTE;
			alt_q[2]  <= uis_pkg::RST_BYTE;
			line_q    <= '0;
			port_q    <= '0;
			irq_mask_q <= uis_pkg::RST_BYTE;
		end else if (wr) begin
			if (idx == uis_pkg::IDX_BAUD_HIGH) begin
				if (line_q.alt_map) alt_q[0] <= pwdata[7:0];
				else baud_hi_q <= pwdata[7:0];
			end else if (idx == uis_pkg::IDX_BAUD_LOW) begin
				if (line_q.alt_map) alt_q[1] <= pwdata[7:0];
				else baud_lo_q <= pwdata[7:0];
			end else if (idx == uis_pkg::IDX_CONTROL_ONE) begin
				if (line_q.alt_map) alt_q[2] <= pwdata[7:0];
				else ctrl1_q <= pwdata[7:0];
			end else if (idx == uis_pkg::IDX_STATUS_TWO) begin
				line_q <= {pwdata[uis_pkg::ALT_MAP_BIT], pwdata[uis_pkg::TX_INVERT_BIT],
					pwdata[uis_pkg::RX_INVERT_BIT], pwdata[uis_pkg::LONG_BREAK_BIT],
					pwdata[uis_pkg::TX_DRIVE_BIT]};
			end else if (idx == uis_pkg::IDX_PORT_CONTROL) begin
				// Fields listed in struct order, each taken from its bit position
				port_q <= {pwdata[uis_pkg::SINGLE_WIRE_BIT], pwdata[uis_pkg::PW_LSB +: 2],
					pwdata[uis_pkg::IR_EN_BIT], pwdata[uis_pkg::RX_EN_BIT],
					pwdata[uis_pkg::TX_EN_BIT], pwdata[uis_pkg::SEND_BREAK_BIT]};
			end else if (idx == uis_pkg::IDX_IRQ_MASK) begin
				irq_mask_q <= pwdata[7:0];
			end
		end
	end

	// Ninth transmit bit and factory test bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_ninth_q <= 1'b0;
			test_q     <= 3'h0;
		end else if (wr && idx == uis_pkg::IDX_DATA_HIGH) begin
			tx_ninth_q <= pwdata[uis_pkg::TX_NINTH_BIT];
			if (special_mode) test_q <= pwdata[2:0];
		end
	end

	// Baud generator: x32 at half the divisor, x16 on every other x32 tick
	assign sbr  = {baud_hi_q, baud_lo_q};
	assign half = (sbr[15:1] == 15'h0) ? 16'h0001 : {1'b0, sbr[15:1]};
	// Reaching or passing the end ticks, so a smaller divisor never stalls the count
	assign x32_tick = (sbr != 16'h0000) && (div_cnt_q >= half - 16'h0001);
	assign x16_tick = x32_tick && x16_ph_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt_q <= 16'h0000;
			x16_ph_q  <= 1'b0;
		end else if (sbr == 16'h0000) begin
			div_cnt_q <= 16'h0000;
			x16_ph_q  <= 1'b0;
		end else if (x32_tick) begin
			div_cnt_q <= 16'h0000;
			x16_ph_q  <= !x16_ph_q;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	// Transmit holding register; empty after reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_hold_q <= uis_pkg::RST_BYTE;
			tdre_q    <= 1'b1;
		end else if (wr && idx == uis_pkg::IDX_DATA_LOW) begin
			tx_hold_q <= pwdata[7:0];
			tdre_q    <= 1'b0;
		end else if (tx_state_q == uis_pkg::TX_IDLE && port_q.tx_en && !port_q.send_break && !tdre_q) begin
			tdre_q    <= 1'b1;
		end
	end

	// Break length counts zero bits only; the receiver framing check ignores it
	assign brk_len = (line_q.long_break ? uis_pkg::BREAK_BITS_LONG : uis_pkg::BREAK_BITS_SHORT)
		+ {3'h0, nine};

	// Transmitter, paced by x32 ticks only, independent of the receiver
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_state_q <= uis_pkg::TX_IDLE;
			tx_sh_q    <= 11'h7FF;
			tx_bits_q  <= 4'h0;
			tx_ph_q    <= 5'h00;
		end else begin
			case (tx_state_q)
				uis_pkg::TX_IDLE: begin
					tx_ph_q   <= 5'h00;
					tx_bits_q <= 4'h0;
					if (port_q.tx_en && port_q.send_break) begin
						tx_sh_q    <= 11'h000;
						tx_state_q <= uis_pkg::TX_BREAK;
					end else if (port_q.tx_en && !tdre_q) begin
						tx_sh_q    <= {1'b1, nine ? tx_ninth_q : 1'b1, tx_hold_q, 1'b0};
						tx_state_q <= uis_pkg::TX_FRAME;
					end
				end
				uis_pkg::TX_FRAME, uis_pkg::TX_BREAK: begin
					if (x32_tick) begin
						tx_ph_q <= tx_ph_q + 5'h01;
						if (tx_ph_q == 5'h1F) begin
							// Break fills with zeros so long breaks stay low past 11 bits
							tx_sh_q   <= {tx_state_q == uis_pkg::TX_FRAME, tx_sh_q[10:1]};
							tx_bits_q <= tx_bits_q + 4'h1;
							if (tx_bits_q == ((tx_state_q == uis_pkg::TX_BREAK) ? brk_len : frame_len) - 4'h1) begin
								tx_state_q <= uis_pkg::TX_IDLE;
							end
						end
					end
				end
				default: tx_state_q <= uis_pkg::TX_IDLE;
			endcase
		end
	end

	assign tx_bit = (tx_state_q == uis_pkg::TX_IDLE) ? 1'b1 : tx_sh_q[0];

	// Pulse widths in x32 ticks; fine enough for the 2.4-115.2 kbit/s span only
	always_comb begin
		case (port_q.pulse_width)
			uis_pkg::PW_1_32: pw_len = 5'h01;
			uis_pkg::PW_1_16: pw_len = 5'h02;
			uis_pkg::PW_3_16: pw_len = 5'h06;
			default:          pw_len = 5'h08;
		endcase
	end

	// Pulse centred about the middle x32 slot of the bit
	assign ir_pulse = !tx_bit && (tx_ph_q >= uis_pkg::BIT_CENTRE - (pw_len >> 1))
		&& (tx_ph_q < uis_pkg::BIT_CENTRE - (pw_len >> 1) + pw_len);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txd_out <= 1'b1;
		end else if (port_q.ir_en) begin
			txd_out <= ir_pulse ^ line_q.tx_invert;
		end else begin
			txd_out <= tx_bit ^ line_q.tx_invert;
		end
	end

	// Enable active low; released in single-wire mode unless driving
	assign txd_oe_n = port_q.single_wire && !line_q.single_wire_tx_drive;

	// Receive source: transmit pin in single-wire mode
	assign rx_pin = port_q.single_wire ? txd_in : rxd_in;
	assign rx_lvl = rx_pin ^ line_q.rx_invert;

	// Infrared stretch: a pulse holds a zero for one bit of x16 ticks
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stretch_q <= 5'h00;
		end else if (port_q.ir_en && rx_lvl) begin
			stretch_q <= uis_pkg::STRETCH_TICKS;
		end else if (x16_tick && stretch_q != 5'h00) begin
			stretch_q <= stretch_q - 5'h01;
		end
	end

	assign rx_bit = port_q.ir_en ? (stretch_q == 5'h00) : rx_lvl;

	assign rx_stop_bit = (rx_idx_q == frame_len - 4'h1);
	assign rx_done = (rx_state_q == uis_pkg::RX_FRAME) && x16_tick
		&& rx_cnt_q == uis_pkg::MID_SAMPLE && rx_stop_bit;

	// Receiver: 16 samples per bit, majority replaced by mid-bit sample
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_state_q <= uis_pkg::RX_IDLE;
			rx_cnt_q   <= 4'h0;
			rx_idx_q   <= 4'h0;
			rx_sh_q    <= 9'h000;
		end else if (!port_q.rx_en) begin
			rx_state_q <= uis_pkg::RX_IDLE;
		end else if (x16_tick) begin
			case (rx_state_q)
				uis_pkg::RX_IDLE: begin
					rx_cnt_q <= 4'h1;
					rx_idx_q <= 4'h0;
					if (!rx_bit) rx_state_q <= uis_pkg::RX_FRAME;
				end
				uis_pkg::RX_FRAME: begin
					rx_cnt_q <= rx_cnt_q + 4'h1;
					if (rx_cnt_q == uis_pkg::MID_SAMPLE) begin
						if (rx_idx_q == 4'h0 && rx_bit) begin
							rx_state_q <= uis_pkg::RX_IDLE;
						end else if (rx_stop_bit) begin
							rx_state_q <= uis_pkg::RX_IDLE;
						end else if (rx_idx_q != 4'h0) begin
							rx_sh_q <= {rx_bit, rx_sh_q[8:1]};
						end
					end
					if (rx_cnt_q == 4'hF) rx_idx_q <= rx_idx_q + 4'h1;
				end
				default: rx_state_q <= uis_pkg::RX_IDLE;
			endcase
		end
	end

	// Received data; eight-bit frames shift one place less
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_data_q  <= uis_pkg::RST_BYTE;
			rx_ninth_q <= 1'b0;
		end else if (rx_done) begin
			rx_data_q  <= nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
			rx_ninth_q <= nine ? rx_sh_q[8] : 1'b0;
		end
	end

	// Active flag and idle detection on consecutive ones
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			raf_q        <= 1'b0;
			ones_q       <= 8'h00;
			idle_armed_q <= 1'b0;
		end else if (port_q.rx_en && x16_tick) begin
			if (rx_state_q == uis_pkg::RX_IDLE && !rx_bit) begin
				raf_q        <= 1'b1;
				idle_armed_q <= 1'b1;
				ones_q       <= 8'h00;
			end else if (!rx_bit) begin
				ones_q <= 8'h00;
			end else if (ones_q == (nine ? uis_pkg::IDLE_TICKS_9 : uis_pkg::IDLE_TICKS_8) - 8'h01) begin
				ones_q       <= 8'h00;
				idle_armed_q <= 1'b0;
				raf_q        <= 1'b0;
			end else if (idle_armed_q) begin
				ones_q <= ones_q + 8'h01;
			end
		end
	end

	// Interrupt events; set wins over a same-cycle clear
	always_comb begin
		ev = 8'h00;
		ev[uis_pkg::EV_TX_EMPTY]  = tx_state_q == uis_pkg::TX_IDLE && port_q.tx_en
			&& !port_q.send_break && !tdre_q;
		ev[uis_pkg::EV_RX_FULL]   = rx_done;
		ev[uis_pkg::EV_IDLE]      = raf_q && port_q.rx_en && x16_tick && rx_bit && idle_armed_q
			&& ones_q == (nine ? uis_pkg::IDLE_TICKS_9 : uis_pkg::IDLE_TICKS_8) - 8'h01;
		ev[uis_pkg::EV_FRAME_ERR] = rx_done && !rx_bit;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_st_q <= 8'h00;
		end else begin
			irq_st_q <= (irq_st_q & ~((wr && idx == uis_pkg::IDX_IRQ_STATUS) ? pwdata[7:0] : 8'h00)) | ev;
		end
	end

	assign irq = |(irq_st_q & irq_mask_q);

	// Checks
	sequence s_data_low_write;
		psel && penable && pwrite && paddr == {2'h0, uis_pkg::IDX_DATA_LOW, 2'h0};
	endsequence

	a_tdre_clear: assert property (@(posedge clk) disable iff (!rstn)
		s_data_low_write |=> !tdre_q) else $error("holding register not marked full");
	a_ninth_kept: assert property (@(posedge clk) disable iff (!rstn)
		tx_state_q == uis_pkg::TX_FRAME |-> $stable(tx_ninth_q) || $past(wr))
		else $error("ninth transmit bit changed without a write");
	a_test_locked: assert property (@(posedge clk) disable iff (!rstn)
		!special_mode |=> $stable(test_q)) else $error("test bits written outside special mode");
	a_raf_sets: assert property (@(posedge clk) disable iff (!rstn)
		port_q.rx_en && x16_tick && rx_state_q == uis_pkg::RX_IDLE && !rx_bit |=> raf_q && rx_state_q == uis_pkg::RX_FRAME)
		else $error("start not flagged");
	a_break_end: assert property (@(posedge clk) disable iff (!rstn)
		tx_state_q == uis_pkg::TX_BREAK ##1 tx_state_q == uis_pkg::TX_IDLE |-> tx_bits_q == brk_len)
		else $error("break length wrong");
	a_nrz_level: assert property (@(posedge clk) disable iff (!rstn)
		!port_q.ir_en ##1 !port_q.ir_en |-> txd_out == ($past(tx_bit) ^ $past(line_q.tx_invert)))
		else $error("line level does not follow bit and inversion");
	a_ir_one_quiet: assert property (@(posedge clk) disable iff (!rstn)
		port_q.ir_en && tx_bit && $stable(port_q.ir_en) |=> txd_out == $past(line_q.tx_invert))
		else $error("pulse sent for a one bit");
	a_ir_stretch: assert property (@(posedge clk) disable iff (!rstn)
		port_q.ir_en && rx_lvl |=> !rx_bit [*2]) else $error("received pulse not stretched to zero");
	a_event_sticky: assert property (@(posedge clk) disable iff (!rstn)
		ev[uis_pkg::EV_RX_FULL] |=> irq_st_q[uis_pkg::EV_RX_FULL]) else $error("event lost");
endmodule : uis_top

// *** dv/uis_remote.sv ***
// Remote serial device model: drives the receive pin, decodes the transmit pin
module uis_remote (
	// Clock
	input  wire logic clk,
	// Serial pins
	output logic      rxd_in,
	input  wire logic txd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Divisor 2 gives one x32 tick per clock
	localparam int BIT_CLKS = 32;
	initial rxd_in = 1'b1;
	// Idle level: mark for NRZ, no pulse for infrared
	task automatic idle(input logic inv, input logic ir);
		rxd_in <= ir ? inv : ~inv;
	endtask : idle
	// Long preamble lets any glitch frame from a level change run out
	task automatic send(input logic [8:0] d, input int n, input logic inv, input logic ir);
		logic b;
		idle(inv, ir);
		repeat (400) @(posedge clk);
		for (int i = 0; i < n + 2; i++) begin
			b = (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i-1];
			if (ir) begin
				repeat (13) @(posedge clk);
				if (!b) rxd_in <= ~inv;
				repeat (6) @(posedge clk);
				rxd_in <= inv;
				repeat (13) @(posedge clk);
			end else begin
				rxd_in <= b ^ inv;
				repeat (BIT_CLKS) @(posedge clk);
			end
		end
		idle(inv, ir);
	endtask : send
	// Samples mid-bit after the start bit, LSB first
	task automatic grab(output logic [8:0] d, input int n, input logic inv);
		d = '0;
		while (txd_out === ~inv) @(posedge clk);
		repeat (16) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			d[i] = txd_out ^ inv;
		end
		repeat (2 * BIT_CLKS) @(posedge clk);
	endtask : grab
endmodule : uis_remote

// *** dv/uart_irda_status_data_path_bench.sv ***
// Self-checking bench of the serial port slice
module uart_irda_status_data_path_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, psel, penable, pwrite, special_mode;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, rxd_in, txd_in, txd_out, txd_oe_n, irq, err, lvl;
	logic [8:0]  d;
	int          num_errors = 0, checked = 0, run = 0, hi_len = 0, lo_len = 0;
	int          pw_clks [4] = '{6, 2, 1, 8};
	// Pin with pull-up when released
	assign txd_in = txd_oe_n ? 1'b1 : txd_out;
	uis_top uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.special_mode(special_mode), .rxd_in(rxd_in), .txd_in(txd_in), .txd_out(txd_out),
		.txd_oe_n(txd_oe_n), .irq(irq));
	uis_remote rem (.clk(clk), .rxd_in(rxd_in), .txd_out(txd_out));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Length of the last finished run of each line level
	always @(posedge clk) begin
		if (txd_out === lvl) run++;
		else begin
			if (lvl) hi_len = run;
			else lo_len = run;
			lvl = txd_out;
			run = 1;
		end
	end
	task automatic end_sim;
		if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rc
	task automatic t_reset_map;
		rc(8'h14, 32'h0);
		rc(8'h1C, 32'h0);
		rc(8'h04, 32'h4);
		rc(8'h0C, 32'h0);
		chk(err, 32'h1);
		chk(pready, 32'h1);
		wr(8'h00, 32'h12);
		wr(8'h14, 32'h81);
		rc(8'h14, 32'h80);
		wr(8'h00, 32'h34);
		rc(8'h00, 32'h34);
		wr(8'h14, 32'h00);
		rc(8'h00, 32'h12);
		wr(8'h00, 32'h00);
		wr(8'h04, 32'h02);
		wr(8'h20, 32'h03);
		rc(8'h20, 32'h03);
	endtask : t_reset_map
	task automatic t_tx;
		wr(8'h1C, 32'hA5);
		rem.grab(d, 8, 1'b0);
		chk(d, 32'hA5);
		wr(8'h14, 32'h10);
		wt(4);
		chk(txd_out, 32'h0);
		wr(8'h1C, 32'h3C);
		rem.grab(d, 8, 1'b1);
		chk(d, 32'h3C);
		wr(8'h14, 32'h00);
	endtask : t_tx
	task automatic t_nine;
		wr(8'h08, 32'h10);
		wr(8'h18, 32'h40);
		wr(8'h1C, 32'h3C);
		rem.grab(d, 9, 1'b0);
		chk(d, 32'h13C);
		wr(8'h1C, 32'h11);
		rem.grab(d, 9, 1'b0);
		chk(d, 32'h111);
		rc(8'h18, 32'h40);
		wr(8'h18, 32'h80);
		rc(8'h18, 32'h00);
		wr(8'h18, 32'h07);
		rc(8'h18, 32'h00);
		special_mode <= 1'b1;
		wr(8'h18, 32'h07);
		rc(8'h18, 32'h07);
		wr(8'h18, 32'h00);
		special_mode <= 1'b0;
	endtask : t_nine
	task automatic t_rx;
		wr(8'h28, 32'h02);
		fork
			rem.send(9'h15A, 9, 1'b0, 1'b0);
			begin
				wt(500);
				rc(8'h14, 32'h01);
				wr(8'h1C, 32'hC3);
				rem.grab(d, 9, 1'b0);
				chk(d, 32'h0C3);
			end
		join
		rc(8'h1C, 32'h5A);
		rc(8'h18, 32'h80);
		chk(irq, 32'h1);
		wr(8'h28, 32'h00);
		wt(1);
		chk(irq, 32'h0);
		wr(8'h24, 32'h02);
		apb(1'b0, 8'h24, 32'h0);
		chk(r[1], 32'h0);
		wt(400);
		rc(8'h14, 32'h00);
		rem.idle(1'b1, 1'b0);
		wr(8'h14, 32'h08);
		rem.send(9'h0A5, 9, 1'b1, 1'b0);
		rc(8'h1C, 32'hA5);
		rem.idle(1'b0, 1'b1);
		wr(8'h14, 32'h00);
		wr(8'h20, 32'h07);
		rem.send(9'h096, 9, 1'b0, 1'b1);
		rc(8'h1C, 32'h96);
		wr(8'h08, 32'h00);
	endtask : t_rx
	task automatic t_ir_tx;
		for (int pw = 0; pw < 4; pw++) begin
			wr(8'h20, 32'h05 | (pw << 3));
			wt(400);
			wr(8'h1C, 32'h00);
			wt(200);
			chk(hi_len, pw_clks[pw]);
		end
		wr(8'h20, 32'h05);
		wr(8'h14, 32'h10);
		wt(400);
		wr(8'h1C, 32'h00);
		wt(200);
		chk(lo_len, 32'h6);
		wr(8'h14, 32'h00);
	endtask : t_ir_tx
	task automatic t_break_wire;
		wr(8'h20, 32'h01);
		wt(400);
		for (int lb = 0; lb < 2; lb++) begin
			wr(8'h14, lb ? 32'h04 : 32'h00);
			wr(8'h20, 32'h41);
			while (txd_out !== 1'b0) @(posedge clk);
			wr(8'h20, 32'h01);
			wt(600);
			chk(lo_len, lb ? 32'd416 : 32'd320);
		end
		chk(txd_oe_n, 32'h0);
		wr(8'h20, 32'h21);
		wt(1);
		chk(txd_oe_n, 32'h1);
		wr(8'h14, 32'h02);
		wt(1);
		chk(txd_oe_n, 32'h0);
	endtask : t_break_wire
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		special_mode = 1'b0;
		lvl = 1'b1;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_reset_map;
		t_tx;
		t_nine;
		t_rx;
		t_ir_tx;
		t_break_wire;
		end_sim;
	end
	// Whole run needs about 9000 clocks
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		end_sim;
	end
endmodule : uart_irda_status_data_path_bench
